// *** verilog/sdram_mode_and_command_decode.sv ***
// Purpose: configuration register, command decode and burst column sequencing
// Assumes: pins pass two flip-flops first; edge n below is the edge the command leaves the synchroniser
// Notes: read data comes from the array side through a two-entry buffer, or straight to dq when the buffer is empty at slot time
`timescale 1ns/1ns
module sdram_mode_and_command_decode #(
    parameter int COL_BITS = 10,
    parameter int DATA_W = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [sdram_cfg_pkg::ADDR_W-1:0] addr_i,
    input wire logic bank_select_lo_i,
    input wire logic bank_select_hi_i,
    input wire logic dqm_i,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic [sdram_cfg_pkg::CFG_W-1:0] config_o,
    output logic config_invalid_o,
    output sdram_cfg_pkg::cmd_t cmd_o,
    output logic [sdram_cfg_pkg::BANK_W-1:0] cmd_bank_o,
    output logic [sdram_cfg_pkg::ADDR_W-1:0] cmd_row_o,
    output logic auto_precharge_o,
    output logic precharge_all_o,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [sdram_cfg_pkg::BANK_W-1:0] acc_bank_o,
    output logic [COL_BITS-1:0] acc_col_o,
    output logic [DATA_W-1:0] acc_wdata_o,
    output logic acc_wmask_o,
    input wire logic [DATA_W-1:0] rd_data_i,
    input wire logic rd_valid_i,
    output logic rd_ready_o
);
    import sdram_cfg_pkg::*;

    localparam int PIN_W = 7 + ADDR_W + BANK_W + DATA_W;

    // two-stage synchroniser for every pin; stage one feeds stage two only
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic cke_s;
    logic cs_n_s;
    logic [2:0] stb_s;
    logic [ADDR_W-1:0] addr_s;
    logic [BANK_W-1:0] bank_s;
    logic dqm_s;
    logic [DATA_W-1:0] dq_s;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, dqm_i, addr_i,
                         bank_select_hi_i, bank_select_lo_i, dq_i, 1'b0};
            pin_sync <= pin_meta;
        end
    end

    assign {cke_s, cs_n_s, stb_s, dqm_s, addr_s, bank_s, dq_s} = pin_sync[PIN_W-1:1];

    // command decode
    cmd_t dec;

    always_comb
    begin
        dec = CMD_NONE;
        if (!cs_n_s)
        begin
            unique case (stb_s)
                STB_NOP: dec = CMD_NOP;
                STB_ACTIVATE: dec = CMD_ACTIVATE;
                STB_READ: dec = CMD_READ;
                STB_WRITE: dec = CMD_WRITE;
                STB_STOP: dec = CMD_STOP;
                STB_PRECHARGE: dec = CMD_PRECHARGE;
                STB_REFRESH: dec = cke_s ? CMD_REFRESH : CMD_SELF_REFRESH;
                STB_LOAD: dec = CMD_CONFIG_LOAD;
            endcase
        end
        // with the clock gate low only the self-refresh entry is meaningful
        if (!cke_s && dec != CMD_SELF_REFRESH)
        begin
            dec = CMD_NONE;
        end
    end

    logic rd_dec;
    logic wr_dec;
    logic stop_dec;
    logic load_dec;
    assign rd_dec = (dec == CMD_READ);
    assign wr_dec = (dec == CMD_WRITE);
    assign stop_dec = (dec == CMD_STOP);
    assign load_dec = (dec == CMD_CONFIG_LOAD);

    // configuration register; no reset pin on the real part, cleared here for determinism
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            config_o <= CFG_RESET;
        end
        else if (load_dec)
        begin
            config_o <= addr_s;
        end
    end

    logic [BL_W-1:0] cfg_bl;
    logic cfg_order;
    logic [LAT_W-1:0] cfg_lat;
    logic [OPMODE_W-1:0] cfg_mode;
    logic cfg_wbm;
    assign cfg_bl = config_o[BL_LSB +: BL_W];
    assign cfg_order = config_o[ORDER_BIT];
    assign cfg_lat = config_o[LAT_LSB +: LAT_W];
    assign cfg_mode = config_o[OPMODE_LSB +: OPMODE_W];
    assign cfg_wbm = config_o[WBM_BIT];

    // reserved encodings are flagged rather than trusted; the controller must avoid them
    assign config_invalid_o = (cfg_mode != OPMODE_NORMAL)
        || !(cfg_bl inside {BL_ONE, BL_TWO, BL_FOUR, BL_EIGHT, BL_FULL})
        || !(cfg_lat inside {LAT_TWO, LAT_THREE})
        || (cfg_bl == BL_FULL && cfg_order);

    // block mask per burst length; all ones for a whole row
    logic [COL_BITS-1:0] bl_mask;
    logic bl_full;

    always_comb
    begin
        bl_full = 1'b0;
        bl_mask = '0;
        unique case (cfg_bl)
            BL_TWO: bl_mask = COL_BITS'(1);
            BL_FOUR: bl_mask = COL_BITS'(3);
            BL_EIGHT: bl_mask = COL_BITS'(7);
            BL_FULL:
            begin
                bl_mask = '1;
                bl_full = 1'b1;
            end
            default: bl_mask = '0;
        endcase
    end

    // burst sequencer
    burst_state_t state;
    logic [COL_BITS-1:0] start_col;
    logic [COL_BITS-1:0] mask;
    logic full;
    logic order;
    logic [BANK_W-1:0] bank;
    logic [COL_BITS-1:0] beat_k;
    logic [COL_BITS-1:0] next_k;
    logic [COL_BITS-1:0] next_off;
    logic [COL_BITS-1:0] next_col;
    logic [COL_BITS-1:0] cmd_mask;
    logic cmd_full;
    logic cont_beat;

    assign next_k = beat_k + COL_BITS'(1);
    // interleaved full row is unsupported, so a full row always counts up
    assign next_off = (order && !full) ? (start_col ^ next_k) : (start_col + next_k);
    assign next_col = (start_col & ~mask) | (next_off & mask);
    assign cont_beat = (state != S_IDLE) && !stop_dec && !rd_dec && !wr_dec;
    assign cmd_mask = (wr_dec && cfg_wbm) ? '0 : bl_mask;
    assign cmd_full = (wr_dec && cfg_wbm) ? 1'b0 : bl_full;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= S_IDLE;
            start_col <= '0;
            mask <= '0;
            full <= 1'b0;
            order <= 1'b0;
            bank <= '0;
            beat_k <= '0;
        end
        else if (rd_dec || wr_dec)
        begin
            start_col <= addr_s[COL_BITS-1:0];
            bank <= bank_s;
            mask <= cmd_mask;
            full <= cmd_full;
            order <= cfg_order;
            beat_k <= '0;
            if (cmd_mask == '0 && !cmd_full)
            begin
                state <= S_IDLE;
            end
            else
            begin
                state <= rd_dec ? S_READ : S_WRITE;
            end
        end
        else if (stop_dec)
        begin
            state <= S_IDLE;
        end
        else if (state != S_IDLE)
        begin
            beat_k <= next_k;
            if (next_k == mask && !full)
            begin
                state <= S_IDLE;
            end
        end
    end

    // one array access per beat; write data and mask ride with their beat
    logic issue;
    logic issue_write;
    assign issue = rd_dec || wr_dec || cont_beat;
    assign issue_write = wr_dec || (cont_beat && state == S_WRITE);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acc_valid_o <= 1'b0;
            acc_write_o <= 1'b0;
            acc_bank_o <= '0;
            acc_col_o <= '0;
            acc_wdata_o <= '0;
            acc_wmask_o <= 1'b0;
        end
        else
        begin
            acc_valid_o <= issue;
            acc_write_o <= issue_write;
            acc_bank_o <= (rd_dec || wr_dec) ? bank_s : bank;
            acc_col_o <= (rd_dec || wr_dec) ? addr_s[COL_BITS-1:0] : next_col;
            acc_wdata_o <= dq_s;
            acc_wmask_o <= issue_write && dqm_s;
        end
    end

    // command event outputs
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cmd_o <= CMD_NONE;
            cmd_bank_o <= '0;
            cmd_row_o <= '0;
            auto_precharge_o <= 1'b0;
            precharge_all_o <= 1'b0;
        end
        else
        begin
            cmd_o <= dec;
            cmd_bank_o <= bank_s;
            cmd_row_o <= addr_s;
            // full-row bursts never auto-precharge
            auto_precharge_o <= (rd_dec || wr_dec) && addr_s[10] && !cmd_full;
            precharge_all_o <= (dec == CMD_PRECHARGE) && addr_s[10];
        end
    end

    // read slot pipeline: beat issued before edge n+1 lands on dq at edge n+latency
    logic [1:0] rd_pipe;
    logic rd_beat;
    logic lat2;
    logic fire;
    logic pre_drive;
    logic dqm_d1;
    logic [DATA_W-1:0] buf_data;
    logic buf_valid;
    logic buf_push;

    // an empty buffer at slot time passes the word straight through, so latency two is met
    assign buf_push = rd_valid_i && !(fire && !buf_valid);

    assign rd_beat = rd_dec || (cont_beat && state == S_READ);
    assign lat2 = (cfg_lat == LAT_TWO);
    assign fire = lat2 ? rd_pipe[0] : rd_pipe[1];
    assign pre_drive = lat2 ? rd_beat : rd_pipe[0];

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_pipe <= '0;
            dqm_d1 <= 1'b0;
        end
        else
        begin
            rd_pipe <= {rd_pipe[0], rd_beat};
            dqm_d1 <= dqm_s;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dq_o <= '0;
            dq_oe_o <= 1'b0;
        end
        else
        begin
            if (fire && buf_valid)
            begin
                dq_o <= buf_data;
            end
            else if (fire && rd_valid_i)
            begin
                dq_o <= rd_data_i;
            end
            // mask seen two edges ago floats this slot
            dq_oe_o <= (pre_drive || fire) && !dqm_d1;
        end
    end

    // a slow array misses its slot; the buffer holds the late word until the next slot drains it
    beat_buffer #(
        .W(DATA_W)
    ) u_rd_buffer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(buf_push),
        .in_ready_o(rd_ready_o),
        .in_data_i(rd_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(fire),
        .out_data_o(buf_data)
    );

    sequence s_quiet3;
        (!rd_dec && !wr_dec && !stop_dec)[*3];
    endsequence

    sequence s_rd_bl4(bit ord);
        rd_dec && cfg_bl == BL_FOUR && cfg_order == ord;
    endsequence

    AST_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        load_dec |=> config_o == $past(addr_s))
        else $error("configuration load did not take the address");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !load_dec |=> $stable(config_o))
        else $error("configuration changed without a load");
    AST_SEQ4: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_rd_bl4(1'b0) ##1 s_quiet3 |-> acc_col_o[1:0] == 2'($past(addr_s[1:0], 3) + 2'h2))
        else $error("sequential beat offset wrong");
    AST_INT4: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_rd_bl4(1'b1) ##1 s_quiet3 |-> acc_col_o[1:0] == ($past(addr_s[1:0], 3) ^ 2'h2))
        else $error("interleaved beat offset wrong");
    AST_BLOCK4: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_rd_bl4(1'b0) ##1 s_quiet3 |-> acc_col_o[COL_BITS-1:2] == $past(addr_s[COL_BITS-1:2], 3))
        else $error("burst left its block");
    AST_LAT2: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_dec && lat2 |-> ##1 fire)
        else $error("latency two slot missed");
    AST_LAT3: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_dec && cfg_lat == LAT_THREE |-> !fire ##1 !fire ##1 fire)
        else $error("latency three slot missed");
    AST_DRIVE3: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rd_dec && cfg_lat == LAT_THREE && !dqm_s |-> ##2 dq_oe_o)
        else $error("outputs not driving one edge before data");
    AST_WBM: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_dec && cfg_wbm |=> state == S_IDLE)
        else $error("single-location write became a burst");
    AST_FULLROW: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == S_READ && full && !stop_dec && !wr_dec |=> state == S_READ)
        else $error("full-row burst ended without a stop");
    AST_STOP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        stop_dec |=> state == S_IDLE ##1 !acc_valid_o || $past(rd_dec || wr_dec))
        else $error("burst stop did not end the burst");
    AST_WMASK: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_dec && dqm_s |=> acc_valid_o && acc_write_o && acc_wmask_o)
        else $error("masked write not blocked");
    AST_DESELECT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cs_n_s |=> cmd_o == CMD_NONE)
        else $error("deselected cycle produced a command");
    AST_PREALL: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dec == CMD_PRECHARGE |=> precharge_all_o == $past(addr_s[10]))
        else $error("precharge-all flag wrong");
    AST_MODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cfg_mode != OPMODE_NORMAL |-> config_invalid_o)
        else $error("test mode not flagged");
endmodule

// *** verilog/sdram_cfg_pkg.sv ***
// Purpose: shared constants for the memory device configuration and command decode
// Assumes: 12-bit configuration word, four banks, strobes sampled on the rising edge
// Notes: encodings are the pin-level strobe patterns {row, column, write}
package sdram_cfg_pkg;
    localparam int CFG_W = 12;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 2;
    localparam int BL_LSB = 0;
    localparam int BL_W = 3;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int LAT_W = 3;
    localparam int OPMODE_LSB = 7;
    localparam int OPMODE_W = 2;
    localparam int WBM_BIT = 9;
    localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
    localparam logic [BL_W-1:0] BL_ONE = 3'h0;
    localparam logic [BL_W-1:0] BL_TWO = 3'h1;
    localparam logic [BL_W-1:0] BL_FOUR = 3'h2;
    localparam logic [BL_W-1:0] BL_EIGHT = 3'h3;
    localparam logic [BL_W-1:0] BL_FULL = 3'h7;
    localparam logic [LAT_W-1:0] LAT_TWO = 3'h2;
    localparam logic [LAT_W-1:0] LAT_THREE = 3'h3;
    localparam logic [OPMODE_W-1:0] OPMODE_NORMAL = 2'h0;
    localparam logic [2:0] STB_NOP = 3'h7;
    localparam logic [2:0] STB_ACTIVATE = 3'h3;
    localparam logic [2:0] STB_READ = 3'h5;
    localparam logic [2:0] STB_WRITE = 3'h4;
    localparam logic [2:0] STB_STOP = 3'h6;
    localparam logic [2:0] STB_PRECHARGE = 3'h2;
    localparam logic [2:0] STB_REFRESH = 3'h1;
    localparam logic [2:0] STB_LOAD = 3'h0;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_NOP = 4'h1,
        CMD_ACTIVATE = 4'h2,
        CMD_READ = 4'h3,
        CMD_WRITE = 4'h4,
        CMD_STOP = 4'h5,
        CMD_PRECHARGE = 4'h6,
        CMD_REFRESH = 4'h7,
        CMD_SELF_REFRESH = 4'h8,
        CMD_CONFIG_LOAD = 4'h9
    } cmd_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_READ = 3'b010,
        S_WRITE = 3'b100
    } burst_state_t;
endpackage

// *** verilog/beat_buffer.sv ***
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty are exact; in_ready_o drops when both entries hold data
`timescale 1ns/1ns
module beat_buffer #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end
        else
        begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    AST_NO_OVERFLOW: assert property (@(posedge clk_i) disable iff (!nrst_i) count == 2'h2 |-> !in_ready_o)
        else $error("buffer accepts while full");
endmodule

// *** bench/ctrl_model.sv ***
// Purpose: memory controller model driving command, address, mask and data pins
// Assumes: pins change on the falling clock edge
// Notes: released address, bank and data pins show the inverse of the last value, never a stale copy; control pins return to idle
`timescale 1ns/1ns
module ctrl_model (
    input wire logic clk_i,
    output logic cke_o,
    output logic cs_n_o,
    output logic [2:0] stb_n_o,
    output logic [11:0] addr_o,
    output logic [1:0] bank_o,
    output logic dqm_o,
    output logic [7:0] dq_o
);
    initial
    begin
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        stb_n_o = 3'h7;
        addr_o = 12'h000;
        bank_o = 2'h0;
        dqm_o = 1'b0;
        dq_o = 8'h00;
    end

    // one command per call, held for exactly one cycle
    task automatic issue(input logic cke, input logic cs_n, input logic [2:0] stb, input logic [11:0] addr,
        input logic [1:0] bank, input logic dqm, input logic [7:0] dq);
        @(negedge clk_i);
        cke_o = cke;
        cs_n_o = cs_n;
        stb_n_o = stb;
        addr_o = addr;
        bank_o = bank;
        dqm_o = dqm;
        dq_o = dq;
        @(negedge clk_i);
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        stb_n_o = 3'h7;
        addr_o = ~addr;
        bank_o = ~bank;
        dqm_o = 1'b0;
        dq_o = ~dq;
    endtask
endmodule

// *** bench/sdram_mode_and_command_decode_tb.sv ***
// Purpose: self-checking bench for configuration, decode, bursts and read timing
// Assumes: command visible two falling edges after the driver releases it
// Notes: array model answers each read beat with its column xor 5a
`timescale 1ns/1ns
module sdram_mode_and_command_decode_tb;
    import sdram_cfg_pkg::*;
    logic clk_i, nrst_i, cke, cs_n, dqm, rd_valid_i, rd_ready_o, dq_oe_o, arr_en, man_valid;
    logic config_invalid_o, auto_precharge_o, precharge_all_o, acc_valid_o, acc_write_o, acc_wmask_o;
    logic [2:0] stb_n;
    logic [11:0] addr, config_o, cmd_row_o;
    logic [1:0] bank, cmd_bank_o, acc_bank_o;
    logic [7:0] dq, dq_o, rd_data_i, acc_wdata_o, man_data;
    logic [9:0] acc_col_o;
    cmd_t cmd_o;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    ctrl_model ctl (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .stb_n_o(stb_n), .addr_o(addr), .bank_o(bank),
        .dqm_o(dqm), .dq_o(dq));
    sdram_mode_and_command_decode dut (.clk_i(clk_i), .nrst_i(nrst_i), .cke_i(cke), .cs_n_i(cs_n),
        .ras_n_i(stb_n[2]), .cas_n_i(stb_n[1]), .we_n_i(stb_n[0]), .addr_i(addr), .bank_select_lo_i(bank[0]),
        .bank_select_hi_i(bank[1]), .dqm_i(dqm), .dq_i(dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .config_o(config_o),
        .config_invalid_o(config_invalid_o), .cmd_o(cmd_o), .cmd_bank_o(cmd_bank_o), .cmd_row_o(cmd_row_o),
        .auto_precharge_o(auto_precharge_o), .precharge_all_o(precharge_all_o), .acc_valid_o(acc_valid_o),
        .acc_write_o(acc_write_o), .acc_bank_o(acc_bank_o), .acc_col_o(acc_col_o), .acc_wdata_o(acc_wdata_o),
        .acc_wmask_o(acc_wmask_o), .rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // array side answers in the beat's own cycle so no slot misses data; continuous, so no race with stimulus
    assign rd_valid_i = arr_en ? (acc_valid_o & ~acc_write_o) : man_valid;
    assign rd_data_i = arr_en ? (acc_col_o[7:0] ^ 8'h5a) : man_data;

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic k, input logic c, input logic [2:0] s, input logic [11:0] a, input logic [1:0] b);
        ctl.issue(k, c, s, a, b, 1'b0, 8'h00);
        repeat (2) @(negedge clk_i);
    endtask

    // legal encodings only, loaded before any use
    task automatic ld(input logic [11:0] cfg);
        cmd(1'b1, 1'b0, STB_LOAD, cfg, 2'h0);
        check(cmd_o, CMD_CONFIG_LOAD);
        check(config_o, cfg);
        check(config_invalid_o, 1'b0);
    endtask

    task automatic s_decode();
        ld(12'h032);
        cmd(1'b1, 1'b0, STB_ACTIVATE, 12'habc, 2'h2);
        check({cmd_o, cmd_bank_o, cmd_row_o}, {CMD_ACTIVATE, 2'h2, 12'habc});
        cmd(1'b1, 1'b0, STB_PRECHARGE, 12'h400, 2'h1);
        check({cmd_o, precharge_all_o}, {CMD_PRECHARGE, 1'b1});
        cmd(1'b1, 1'b0, STB_PRECHARGE, 12'h000, 2'h3);
        check({cmd_o, precharge_all_o, cmd_bank_o}, {CMD_PRECHARGE, 1'b0, 2'h3});
        cmd(1'b1, 1'b0, STB_NOP, 12'h000, 2'h0);
        check(cmd_o, CMD_NOP);
        cmd(1'b1, 1'b0, STB_STOP, 12'h000, 2'h0);
        check(cmd_o, CMD_STOP);
        cmd(1'b1, 1'b0, STB_REFRESH, 12'h000, 2'h0);
        check(cmd_o, CMD_REFRESH);
        cmd(1'b0, 1'b0, STB_REFRESH, 12'h000, 2'h0);
        check(cmd_o, CMD_SELF_REFRESH);
        cmd(1'b1, 1'b1, STB_LOAD, 12'h123, 2'h0);
        check({cmd_o, config_o}, {CMD_NONE, 12'h032});
    endtask

    task automatic s_burst(input logic [11:0] cfg, input logic [2:0] s, input logic [11:0] a, input int beats,
        input bit ilv, input int bl);
        logic [9:0] base, off, m;
        m = 10'(bl - 1);
        base = a[9:0] & ~m;
        off = a[9:0] & m;
        ld(cfg);
        ctl.issue(1'b1, 1'b0, s, a, 2'h1, s == STB_WRITE, 8'hc3);
        repeat (2) @(negedge clk_i);
        check({auto_precharge_o, acc_bank_o}, {a[10], 2'h1});
        if (s == STB_WRITE)
            check({acc_wmask_o, acc_wdata_o}, {1'b1, 8'hc3});
        for (int k = 0; k < beats; k++)
        begin
            check({acc_valid_o, acc_write_o, acc_col_o},
                {2'b11 & {1'b1, s == STB_WRITE}, base | (ilv ? off ^ 10'(k) : (off + 10'(k)) & m)});
            @(negedge clk_i);
        end
        check(acc_valid_o, 1'b0);
    endtask

    task automatic s_full();
        int n;
        ld(12'h027);
        ctl.issue(1'b1, 1'b0, STB_READ, 12'h3fe, 2'h0, 1'b0, 8'h00);
        n = 0;
        fork
            begin
                repeat (2) @(negedge clk_i);
                ctl.issue(1'b1, 1'b0, STB_STOP, 12'h000, 2'h0, 1'b0, 8'h00);
            end
            begin
                repeat (2) @(negedge clk_i);
                for (int k = 0; k < 8; k++)
                begin
                    if (acc_valid_o === 1'b1)
                    begin
                        check(acc_col_o, 10'(12'h3fe + n));
                        n++;
                    end
                    @(negedge clk_i);
                end
            end
        join
        check(32'(n), 32'h4);
    endtask

    task automatic s_lat(input logic [11:0] cfg, input int m);
        ld(cfg);
        cmd(1'b1, 1'b0, STB_READ, 12'h008, 2'h0);
        check(dq_oe_o, m == 2);
        @(negedge clk_i);
        check(dq_oe_o, 1'b1);
        if (m == 3)
            @(negedge clk_i);
        check(dq_o, 8'h52);
    endtask

    task automatic s_buf();
        ld(12'h021);
        arr_en = 1'b0;
        man_data = 8'h11;
        man_valid = 1'b1;
        @(negedge clk_i);
        man_data = 8'h22;
        @(negedge clk_i);
        man_valid = 1'b0;
        @(negedge clk_i);
        check(rd_ready_o, 1'b0);
        cmd(1'b1, 1'b0, STB_READ, 12'h000, 2'h0);
        @(negedge clk_i);
        check(dq_o, 8'h11);
        @(negedge clk_i);
        check({dq_o, rd_ready_o}, {8'h22, 1'b1});
        arr_en = 1'b1;
    endtask

    initial
    begin
        nrst_i = 1'b0;
        arr_en = 1'b1;
        man_valid = 1'b0;
        man_data = 8'h00;
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1'b1;
        s_decode();
        s_burst(12'h022, STB_READ, 12'h001, 4, 0, 4);
        s_burst(12'h02a, STB_READ, 12'h001, 4, 1, 4);
        s_burst(12'h02b, STB_READ, 12'h40d, 8, 1, 8);
        s_burst(12'h021, STB_WRITE, 12'h003, 2, 0, 2);
        s_burst(12'h223, STB_WRITE, 12'h006, 1, 0, 8);
        s_burst(12'h020, STB_READ, 12'h3ff, 1, 0, 1);
        s_full();
        s_lat(12'h020, 2);
        s_lat(12'h030, 3);
        s_buf();
        summarize();
    end
endmodule
